/* File: rtl/usf_pkg.sv */
// Shared constants and types for the infrared serial port with FIFOs and events.
package usf_pkg;
	localparam int USF_DATA_W = 8;
	localparam int USF_RX_W = 12;
	localparam int USF_RXIN_W = 11;
	localparam int USF_FIFO_DEPTH = 16;
	localparam int USF_CNT_W = 5;
	localparam int USF_EV_W = 7;
	localparam int USF_DIVI_W = 16;
	localparam int USF_DIVF_W = 6;
	localparam int USF_LPDIV_W = 8;
	localparam int USF_TICK_W = 4;
	// Event bit positions.
	localparam int USF_EV_OVR = 0;
	localparam int USF_EV_BRK = 1;
	localparam int USF_EV_PAR = 2;
	localparam int USF_EV_FRM = 3;
	localparam int USF_EV_TMO = 4;
	localparam int USF_EV_TX = 5;
	localparam int USF_EV_RX = 6;
	// Receive word status positions.
	localparam int USF_RXW_FE = 8;
	localparam int USF_RXW_PE = 9;
	localparam int USF_RXW_BE = 10;
	localparam int USF_RXW_OE = 11;
	// Ticks of the 16x reference per bit and per infrared pulse.
	localparam logic [3:0] USF_PHASE_LAST = 4'hF;
	localparam logic [3:0] USF_PULSE_TICKS = 4'h3;
	localparam logic [USF_EV_W-1:0] USF_EV_LEVEL_HOLD = 7'h1F;
	typedef enum logic [2:0] {
		USF_LVL_1_8 = 3'h0,
		USF_LVL_1_4 = 3'h1,
		USF_LVL_1_2 = 3'h2,
		USF_LVL_3_4 = 3'h3,
		USF_LVL_7_8 = 3'h4
	} usf_level_t;
	localparam usf_level_t USF_LVL_RESET = USF_LVL_1_2;
	typedef enum logic [1:0] {
		USF_ENC_IDLE = 2'h1,
		USF_ENC_PULSE = 2'h2
	} usf_enc_t;
	// Fill count in eighths of the depth for a trigger selection.
	function automatic logic [USF_CNT_W-1:0] usf_trig(input logic [2:0] sel, input int depth);
		int k;
		k = 4;
		case (sel)
			USF_LVL_1_8: k = 1;
			USF_LVL_1_4: k = 2;
			USF_LVL_3_4: k = 6;
			USF_LVL_7_8: k = 7;
			default: k = 4;
		endcase
		return USF_CNT_W'((depth * k) / 8);
	endfunction
endpackage

/* File: rtl/usf_fifo.sv */
// Synchronous FIFO with a depth limit and registered read data.
`timescale 1ns/10ps
`default_nettype none
module usf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [CW-1:0] limit,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output var logic in_ready,
	output var logic out_valid,
	output var logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	output var logic [CW-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH || CW < $clog2(DEPTH + 1)) begin : g_chk
		$error("usf_fifo: depth must be a power of two and fit the count");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	wire logic in_fire = in_valid & in_ready;
	wire logic out_fire = out_valid & out_ready;
	wire logic [AW-1:0] rp_d = out_fire ? AW'(rp_q + 1'b1) : rp_q;
	wire logic [CW-1:0] cnt_d = CW'(count + CW'(in_fire) - CW'(out_fire));
	wire logic fwd = in_fire && (wp_q == rp_d);
	always_ff @(posedge sys_clk) begin
		if (in_fire) begin
			mem_q[wp_q] <= in_data;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wp_q <= '0;
			rp_q <= '0;
			count <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			wp_q <= in_fire ? AW'(wp_q + 1'b1) : wp_q;
			rp_q <= rp_d;
			count <= cnt_d;
			in_ready <= cnt_d < limit;
			out_valid <= cnt_d != '0;
			out_data <= fwd ? in_data : mem_q[rp_d];
		end
	end
endmodule
`default_nettype wire

/* File: rtl/usf_sir.sv */
// Infrared pulse encoder and decoder.
`timescale 1ns/10ps
`default_nettype none
module usf_sir
	import usf_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic lowpower,
	input wire logic baud_ref_x16_tick,
	input wire logic lp16_tick,
	input wire logic bit_start,
	input wire logic tx_bit,
	input wire logic rx_line,
	input wire logic rx_block,
	output var logic ir_out,
	output var logic rx_bit
);
	usf_enc_t enc_q;
	usf_enc_t enc_d;
	logic [USF_TICK_W-1:0] pcnt_q;
	logic [USF_TICK_W-1:0] pcnt_d;
	logic [USF_TICK_W-1:0] dcnt_q;
	logic dact_q;
	logic rx_prev_q;
	wire logic pulse_tick = lowpower ? lp16_tick : baud_ref_x16_tick;
	wire logic pulse_end = pulse_tick && (pcnt_q == USF_PULSE_TICKS - 4'h1);
	wire logic rx_fall = rx_prev_q && !rx_line && !rx_block;
	wire logic dec_end = baud_ref_x16_tick && (dcnt_q == USF_PHASE_LAST);
	wire logic dact_d = !rx_block && (rx_fall || (dact_q && !dec_end));
	always_comb begin
		enc_d = enc_q;
		pcnt_d = pcnt_q;
		case (enc_q)
			USF_ENC_IDLE: begin
				if (bit_start && !tx_bit) begin
					enc_d = USF_ENC_PULSE;
					pcnt_d = '0;
				end
			end
			USF_ENC_PULSE: begin
				if (pulse_end) begin
					enc_d = USF_ENC_IDLE;
				end else if (pulse_tick) begin
					pcnt_d = USF_TICK_W'(pcnt_q + 1'b1);
				end
			end
			default: begin
				enc_d = USF_ENC_IDLE;
			end
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			enc_q <= USF_ENC_IDLE;
			pcnt_q <= '0;
			ir_out <= 1'b0;
		end else begin
			enc_q <= enc_d;
			pcnt_q <= pcnt_d;
			ir_out <= enc_d == USF_ENC_PULSE;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_prev_q <= 1'b1;
			dact_q <= 1'b0;
			dcnt_q <= '0;
			rx_bit <= 1'b1;
		end else begin
			rx_prev_q <= rx_line;
			dact_q <= dact_d;
			dcnt_q <= rx_fall ? '0 : (baud_ref_x16_tick ? USF_TICK_W'(dcnt_q + 1'b1) : dcnt_q);
			rx_bit <= !dact_d;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/usf_uart_sir_fifo_irq.sv */
// Infrared serial port core: 16x reference, SIR codec, FIFOs, flags and events.
`timescale 1ns/10ps
`default_nettype none
module usf_uart_sir_fifo_irq
	import usf_pkg::*;
#(
	parameter int DEPTH = USF_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic port_enable,
	input wire logic sir_enable,
	input wire logic sir_lowpower,
	input wire logic loopback_enable,
	input wire logic fifo_enable_bit,
	input wire logic line_ctl_wr,
	input wire logic [USF_DIVI_W-1:0] divisor_int,
	input wire logic [USF_DIVF_W-1:0] divisor_frac,
	input wire logic [USF_LPDIV_W-1:0] lowpower_div,
	input wire logic level_select_wr,
	input wire logic [2:0] tx_level_select,
	input wire logic [2:0] rx_level_select,
	input wire logic [USF_EV_W-1:0] event_mask_bit,
	input wire logic [USF_EV_W-1:0] event_clear,
	input wire logic overrun_clear,
	input wire logic tx_wr_valid,
	input wire logic [USF_DATA_W-1:0] tx_wr_data,
	output var logic tx_wr_ready,
	input wire logic rx_rd_ready,
	output var logic rx_rd_valid,
	output var logic [USF_RX_W-1:0] rx_rd_data,
	output var logic baud_ref_x16,
	output var logic bit_tick,
	output var logic tx_char_valid,
	output var logic [USF_DATA_W-1:0] tx_char_data,
	input wire logic tx_char_ready,
	input wire logic tx_serial_bit,
	input wire logic tx_busy,
	output var logic rx_serial_bit,
	input wire logic rx_char_valid,
	input wire logic [USF_RXIN_W-1:0] rx_char_data,
	output var logic rx_char_ready,
	input wire logic rx_timeout,
	input wire logic serial_in_pin,
	output var logic serial_out_pin,
	output var logic tx_empty_flag,
	output var logic tx_full_flag,
	output var logic rx_empty_flag,
	output var logic rx_full_flag,
	output var logic rx_overrun,
	output var logic [USF_EV_W-1:0] raw_event,
	output var logic [USF_EV_W-1:0] masked_event,
	output var logic irq
);
	if (DEPTH != 8 && DEPTH != 16) begin : g_chk
		$error("usf_uart_sir_fifo_irq: DEPTH must be 8 or 16");
	end

	////////////////////////////////////////////////////////////////////////
	// Line control latch and trigger selections.
	logic fen_q;
	logic [USF_DIVI_W-1:0] divi_q;
	logic [USF_DIVF_W-1:0] divf_q;
	logic [2:0] tx_lvl_q;
	logic [2:0] rx_lvl_q;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fen_q <= 1'b0;
			divi_q <= '0;
			divf_q <= '0;
		end else if (line_ctl_wr) begin
			fen_q <= fifo_enable_bit;
			divi_q <= divisor_int;
			divf_q <= divisor_frac;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_lvl_q <= USF_LVL_RESET;
			rx_lvl_q <= USF_LVL_RESET;
		end else if (level_select_wr) begin
			tx_lvl_q <= tx_level_select;
			rx_lvl_q <= rx_level_select;
		end
	end
	wire logic [USF_CNT_W-1:0] fifo_limit = fen_q ? USF_CNT_W'(DEPTH) : USF_CNT_W'(1);
	wire logic [USF_CNT_W-1:0] tx_trig = usf_trig(tx_lvl_q, DEPTH);
	wire logic [USF_CNT_W-1:0] rx_trig = usf_trig(rx_lvl_q, DEPTH);

	////////////////////////////////////////////////////////////////////////
	// 16x baud reference with fractional divisor.
	logic [USF_DIVI_W:0] bcnt_q;
	logic [USF_DIVF_W-1:0] facc_q;
	logic carry_q;
	logic [USF_TICK_W-1:0] phase_q;
	logic bit_start_q;
	logic ref_tick_q;
	wire logic div_ok = port_enable && (divi_q != '0);
	wire logic [USF_DIVF_W:0] frac_sum = {1'b0, facc_q} + {1'b0, divf_q};
	wire logic [USF_DIVI_W:0] b_len = {1'b0, divi_q} + {{USF_DIVI_W{1'b0}}, carry_q};
	wire logic b_tick = div_ok && (bcnt_q >= b_len);
	wire logic last_phase = b_tick && (phase_q == USF_PHASE_LAST);
	always_ff @(posedge sys_clk) begin
		if (srst || !div_ok) begin
			bcnt_q <= (USF_DIVI_W + 1)'(1);
			facc_q <= '0;
			carry_q <= 1'b0;
			phase_q <= '0;
		end else if (b_tick) begin
			bcnt_q <= (USF_DIVI_W + 1)'(1);
			facc_q <= frac_sum[USF_DIVF_W-1:0];
			carry_q <= frac_sum[USF_DIVF_W];
			phase_q <= USF_TICK_W'(phase_q + 1'b1);
		end else begin
			bcnt_q <= (USF_DIVI_W + 1)'(bcnt_q + 1'b1);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			baud_ref_x16 <= 1'b0;
			bit_tick <= 1'b0;
			bit_start_q <= 1'b0;
			ref_tick_q <= 1'b0;
		end else begin
			baud_ref_x16 <= b_tick;
			bit_tick <= last_phase;
			bit_start_q <= bit_tick;
			// Delayed tick lines up with bit_start_q so a pulse spans three full tick periods.
			ref_tick_q <= baud_ref_x16;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Low-power 16x reference, independent of the baud divisor.
	logic [USF_LPDIV_W-1:0] lpcnt_q;
	logic lp_tick_q;
	wire logic lp_wrap = (lowpower_div != '0) && (lpcnt_q >= USF_LPDIV_W'(lowpower_div - 1'b1));
	always_ff @(posedge sys_clk) begin
		if (srst || lowpower_div == '0) begin
			lpcnt_q <= '0;
			lp_tick_q <= 1'b0;
		end else begin
			lpcnt_q <= lp_wrap ? '0 : USF_LPDIV_W'(lpcnt_q + 1'b1);
			lp_tick_q <= lp_wrap;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit and receive FIFOs.
	logic [USF_CNT_W-1:0] tx_cnt;
	logic [USF_CNT_W-1:0] rx_cnt;
	logic ovr_tag_q;
	wire logic rx_fire = rx_char_valid && rx_char_ready;
	wire logic ovr_set = rx_char_valid && !rx_char_ready;
	usf_fifo #(
		.WIDTH(USF_DATA_W),
		.DEPTH(DEPTH),
		.CW(USF_CNT_W)
	) u_tx_fifo (
		.sys_clk(sys_clk),
		.srst(srst),
		.limit(fifo_limit),
		.in_valid(tx_wr_valid),
		.in_data(tx_wr_data),
		.in_ready(tx_wr_ready),
		.out_valid(tx_char_valid),
		.out_data(tx_char_data),
		.out_ready(tx_char_ready),
		.count(tx_cnt)
	);
	usf_fifo #(
		.WIDTH(USF_RX_W),
		.DEPTH(DEPTH),
		.CW(USF_CNT_W)
	) u_rx_fifo (
		.sys_clk(sys_clk),
		.srst(srst),
		.limit(fifo_limit),
		.in_valid(rx_char_valid),
		.in_data({ovr_tag_q, rx_char_data}),
		.in_ready(rx_char_ready),
		.out_valid(rx_rd_valid),
		.out_data(rx_rd_data),
		.out_ready(rx_rd_ready),
		.count(rx_cnt)
	);
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ovr_tag_q <= 1'b0;
			rx_overrun <= 1'b0;
		end else begin
			ovr_tag_q <= ovr_set || (ovr_tag_q && !rx_fire);
			rx_overrun <= ovr_set || (rx_overrun && !overrun_clear);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_empty_flag <= 1'b1;
			tx_full_flag <= 1'b0;
			rx_empty_flag <= 1'b1;
			rx_full_flag <= 1'b0;
		end else begin
			tx_empty_flag <= tx_cnt == '0;
			tx_full_flag <= tx_cnt >= fifo_limit;
			rx_empty_flag <= rx_cnt == '0;
			rx_full_flag <= rx_cnt >= fifo_limit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial path: pin filter, loopback, half-duplex guard and codec.
	logic [2:0] rxs_q;
	logic rx_filt_q;
	logic ir_out;
	logic dec_bit;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rxs_q <= 3'h7;
			rx_filt_q <= 1'b1;
		end else begin
			rxs_q <= {rxs_q[1:0], serial_in_pin};
			rx_filt_q <= (rxs_q[1] == rxs_q[2]) ? rxs_q[2] : rx_filt_q;
		end
	end
	wire logic line_out = sir_enable ? ir_out : tx_serial_bit;
	wire logic loop_line = sir_enable ? !serial_out_pin : serial_out_pin;
	wire logic rx_line = loopback_enable ? loop_line : rx_filt_q;
	wire logic tx_active = tx_busy || tx_char_valid || ir_out;
	wire logic rx_block = sir_enable && !loopback_enable && tx_active;
	usf_sir u_sir (
		.sys_clk(sys_clk),
		.srst(srst),
		.lowpower(sir_lowpower),
		.baud_ref_x16_tick(ref_tick_q),
		.lp16_tick(lp_tick_q),
		.bit_start(bit_start_q),
		.tx_bit(tx_serial_bit),
		.rx_line(rx_line),
		.rx_block(rx_block),
		.ir_out(ir_out),
		.rx_bit(dec_bit)
	);
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			serial_out_pin <= 1'b0;
			rx_serial_bit <= 1'b1;
		end else begin
			serial_out_pin <= line_out;
			rx_serial_bit <= sir_enable ? dec_bit : rx_line;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event status, mask and interrupt request.
	logic tx_cond_q;
	logic rx_cond_q;
	wire logic tx_cond = fen_q ? (tx_cnt <= tx_trig) : (tx_cnt == '0);
	wire logic rx_cond = fen_q ? (rx_cnt >= rx_trig) : (rx_cnt != '0);
	logic [USF_EV_W-1:0] ev_set;
	always_comb begin
		ev_set = '0;
		ev_set[USF_EV_OVR] = ovr_set;
		ev_set[USF_EV_BRK] = rx_fire && rx_char_data[USF_RXW_BE];
		ev_set[USF_EV_PAR] = rx_fire && rx_char_data[USF_RXW_PE];
		ev_set[USF_EV_FRM] = rx_fire && rx_char_data[USF_RXW_FE];
		ev_set[USF_EV_TMO] = rx_timeout;
		ev_set[USF_EV_TX] = tx_cond && !tx_cond_q;
		ev_set[USF_EV_RX] = rx_cond && !rx_cond_q;
	end
	wire logic [USF_EV_W-1:0] ev_hold = USF_EV_LEVEL_HOLD | {rx_cond, tx_cond, 5'h00};
	wire logic [USF_EV_W-1:0] ev_d = ev_set | (raw_event & ~event_clear & ev_hold);
	wire logic [USF_EV_W-1:0] mev_d = ev_d & event_mask_bit;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_cond_q <= 1'b0;
			rx_cond_q <= 1'b0;
			raw_event <= '0;
			masked_event <= '0;
			irq <= 1'b0;
		end else begin
			tx_cond_q <= tx_cond;
			rx_cond_q <= rx_cond;
			raw_event <= ev_d;
			masked_event <= mev_d;
			irq <= |mev_d;
		end
	end
endmodule
`default_nettype wire

/* File: tb/usf_chk.sv */
// Concurrent checks on the ports of the infrared serial port core.
`timescale 1ns/10ps
`default_nettype none
module usf_chk
	import usf_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic port_enable,
	input wire logic tx_wr_valid,
	input wire logic [USF_DATA_W-1:0] tx_wr_data,
	input wire logic tx_wr_ready,
	input wire logic rx_rd_valid,
	input wire logic baud_ref_x16,
	input wire logic bit_tick,
	input wire logic tx_char_valid,
	input wire logic [USF_DATA_W-1:0] tx_char_data,
	input wire logic rx_char_valid,
	input wire logic rx_char_ready,
	input wire logic [USF_EV_W-1:0] event_clear,
	input wire logic tx_empty_flag,
	input wire logic tx_full_flag,
	input wire logic rx_empty_flag,
	input wire logic rx_full_flag,
	input wire logic rx_overrun,
	input wire logic [USF_EV_W-1:0] raw_event,
	input wire logic [USF_EV_W-1:0] masked_event,
	input wire logic irq
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (srst);
wire logic lost = rx_char_valid && !rx_char_ready;
property p_irq_or; irq == |masked_event; endproperty
a_irq_or: assert property (p_irq_or)
	else $error("irq differs from the OR of masked events");
property p_mask_sub; (masked_event & ~raw_event) == '0; endproperty
a_mask_sub: assert property (p_mask_sub)
	else $error("masked event without raw event");
property p_flags; !(tx_empty_flag && tx_full_flag) && !(rx_empty_flag && rx_full_flag); endproperty
a_flags: assert property (p_flags)
	else $error("empty and full flags both set");
property p_ovr; lost |=> raw_event[USF_EV_OVR] && rx_overrun; endproperty
a_ovr: assert property (p_ovr)
	else $error("lost character raised no overrun");
property p_ovr_clr; event_clear[USF_EV_OVR] && !lost |=> !raw_event[USF_EV_OVR]; endproperty
a_ovr_clr: assert property (p_ovr_clr)
	else $error("overrun event survived its clear");
property p_rst; $fell(srst) |-> tx_empty_flag && rx_empty_flag && raw_event == '0 && !irq; endproperty
a_rst: assert property (p_rst)
	else $error("wrong values after reset");
property p_rx_push; rx_char_valid && rx_char_ready |=> rx_rd_valid; endproperty
a_rx_push: assert property (p_rx_push)
	else $error("stored character not offered to the host");
property p_tx_push;
	!tx_char_valid && tx_wr_valid && tx_wr_ready |=>
		tx_char_valid && tx_char_data == $past(tx_wr_data);
endproperty
a_tx_push: assert property (p_tx_push)
	else $error("pushed byte not at transmit head");
property p_off; !port_enable && !$past(port_enable) |-> !baud_ref_x16 && !bit_tick; endproperty
a_off: assert property (p_off)
	else $error("reference ticks while port disabled");
property p_rx_ev; $rose(raw_event[USF_EV_RX]) |-> !rx_empty_flag; endproperty
a_rx_ev: assert property (p_rx_ev)
	else $error("receive event with empty FIFO");
c_lost: cover property (lost);
c_irq: cover property (irq);
c_rx_full: cover property (rx_full_flag);
c_tx_full: cover property (tx_full_flag && !tx_wr_ready);
endmodule
bind usf_uart_sir_fifo_irq usf_chk chk_u (.sys_clk(sys_clk), .srst(srst),
	.port_enable(port_enable), .tx_wr_valid(tx_wr_valid), .tx_wr_data(tx_wr_data),
	.tx_wr_ready(tx_wr_ready), .rx_rd_valid(rx_rd_valid), .baud_ref_x16(baud_ref_x16),
	.bit_tick(bit_tick), .tx_char_valid(tx_char_valid), .tx_char_data(tx_char_data),
	.rx_char_valid(rx_char_valid), .rx_char_ready(rx_char_ready), .event_clear(event_clear),
	.tx_empty_flag(tx_empty_flag), .tx_full_flag(tx_full_flag), .rx_empty_flag(rx_empty_flag),
	.rx_full_flag(rx_full_flag), .rx_overrun(rx_overrun), .raw_event(raw_event),
	.masked_event(masked_event), .irq(irq));
`default_nettype wire

/* File: tb/usf_partner.sv */
// Model of the shifter and infrared transceiver beyond the core.
`timescale 1ns/10ps
`default_nettype none
module usf_partner (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic stall,
	input wire logic busy,
	input wire logic line_level,
	input wire logic ir_low,
	input wire logic bit_tick,
	output var logic tx_char_ready,
	output var logic tx_serial_bit,
	output var logic tx_busy,
	output var logic serial_in_pin
);
always_ff @(posedge sys_clk) begin
	if (srst) begin
		tx_char_ready <= 1'b0;
		tx_serial_bit <= 1'b1;
	end else begin
		tx_char_ready <= !stall;
		if (bit_tick) begin
			tx_serial_bit <= line_level;
		end
	end
end
// Busy is held by the bench while sending, so received infrared pulses are ignored while it is high.
assign tx_busy = busy;
// A light pulse pulls the pin low; otherwise the pull-up holds it high.
assign serial_in_pin = ir_low ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: tb/uart_sir_fifo_irq_tb_top.sv */
// Self-checking bench for the infrared serial port core.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; \
	$display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module uart_sir_fifo_irq_tb_top;
import usf_pkg::*;
localparam int RXT = 16 * 2 / 8;
logic sys_clk = 0, srst = 1, port_enable = 0, sir_enable = 0, sir_lowpower = 0;
logic fifo_enable_bit = 0, line_ctl_wr = 0, level_select_wr = 0, overrun_clear = 0;
logic [15:0] divisor_int = '0;
logic [7:0] lowpower_div = '0, tx_wr_data = '0;
logic [2:0] tx_level_select = '0, rx_level_select = '0;
logic [6:0] event_mask_bit = '0, event_clear = '0, raw_event, masked_event;
logic tx_wr_valid = 0, rx_rd_ready = 0, rx_char_valid = 0, stall = 1, busy = 0;
logic line_level = 1, ir_low = 0, oe_pend = 0, loopback_enable = 0, rx_timeout = 0;
logic [10:0] rx_char_data = '0;
logic tx_wr_ready, rx_rd_valid, baud_ref_x16, bit_tick, tx_char_valid, tx_char_ready;
logic tx_serial_bit, tx_busy, rx_serial_bit, rx_char_ready, serial_in_pin, serial_out_pin;
logic tx_empty_flag, tx_full_flag, rx_empty_flag, rx_full_flag, rx_overrun, irq;
logic [11:0] rx_rd_data;
logic [7:0] tx_char_data, txe;
logic [7:0] txq[$];
logic [11:0] rxq[$];
int failures = 0, checked = 0, cycles = 0, seed = 56645, hi = 0;
always #2 sys_clk = ~sys_clk;
usf_uart_sir_fifo_irq #(.DEPTH(16)) dut_u (.sys_clk(sys_clk), .srst(srst),
	.port_enable(port_enable), .sir_enable(sir_enable), .sir_lowpower(sir_lowpower),
	.loopback_enable(loopback_enable), .fifo_enable_bit(fifo_enable_bit), .line_ctl_wr(line_ctl_wr),
	.divisor_int(divisor_int), .divisor_frac(6'h00), .lowpower_div(lowpower_div),
	.level_select_wr(level_select_wr), .tx_level_select(tx_level_select),
	.rx_level_select(rx_level_select), .event_mask_bit(event_mask_bit),
	.event_clear(event_clear), .overrun_clear(overrun_clear), .tx_wr_valid(tx_wr_valid),
	.tx_wr_data(tx_wr_data), .tx_wr_ready(tx_wr_ready), .rx_rd_ready(rx_rd_ready),
	.rx_rd_valid(rx_rd_valid), .rx_rd_data(rx_rd_data), .baud_ref_x16(baud_ref_x16),
	.bit_tick(bit_tick), .tx_char_valid(tx_char_valid), .tx_char_data(tx_char_data),
	.tx_char_ready(tx_char_ready), .tx_serial_bit(tx_serial_bit), .tx_busy(tx_busy),
	.rx_serial_bit(rx_serial_bit), .rx_char_valid(rx_char_valid),
	.rx_char_data(rx_char_data), .rx_char_ready(rx_char_ready), .rx_timeout(rx_timeout),
	.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
	.tx_empty_flag(tx_empty_flag), .tx_full_flag(tx_full_flag),
	.rx_empty_flag(rx_empty_flag), .rx_full_flag(rx_full_flag), .rx_overrun(rx_overrun),
	.raw_event(raw_event), .masked_event(masked_event), .irq(irq));
usf_partner far_u (.sys_clk(sys_clk), .srst(srst), .stall(stall), .busy(busy),
	.line_level(line_level), .ir_low(ir_low), .bit_tick(bit_tick),
	.tx_char_ready(tx_char_ready), .tx_serial_bit(tx_serial_bit), .tx_busy(tx_busy),
	.serial_in_pin(serial_in_pin));
////////////////////////////////////////////////////////////////
task give_verdict;
	$display("checks %0d mismatches %0d", checked, failures);
	if (failures == 0 && checked > 0) begin
		$display("All checks passed");
	end else begin
		$display("Checks failed");
	end
	$finish;
endtask
task wait_n(input int n);
	repeat (n) @(posedge sys_clk);
endtask
task push_tx(input logic [7:0] d);
	tx_wr_valid <= 1'b1;
	tx_wr_data <= d;
	do @(posedge sys_clk); while (tx_wr_ready !== 1'b1);
	txq.push_back(d);
endtask
task push_rx(input logic [7:0] d);
	rx_char_valid <= 1'b1;
	rx_char_data <= {3'h0, d};
	@(posedge sys_clk);
	if (rx_char_ready === 1'b1) begin
		rxq.push_back({oe_pend, 3'h0, d});
		oe_pend = 1'b0;
	end else begin
		oe_pend = 1'b1;
	end
	rx_char_valid <= 1'b0;
	@(posedge sys_clk);
endtask
task pop_rx;
	logic [11:0] e;
	rx_rd_ready <= 1'b1;
	do @(posedge sys_clk); while (rx_rd_valid !== 1'b1);
	e = rxq.pop_front();
	`CHK("rx_rd_data", e, rx_rd_data)
	rx_rd_ready <= 1'b0;
	@(posedge sys_clk);
endtask
always @(posedge sys_clk) begin
	cycles++;
	if (!srst && tx_char_valid === 1'b1 && tx_char_ready === 1'b1) begin
		txe = txq.pop_front();
		`CHK("tx_char_data", txe, tx_char_data)
	end
	if (cycles == 30000) begin
		failures++;
		give_verdict;
	end
end
////////////////////////////////////////////////////////////////
initial begin
	wait_n(4);
	srst <= 1'b0;
	wait_n(1);
	`CHK("tx_empty_flag", 1'b1, tx_empty_flag)
	`CHK("rx_empty_flag", 1'b1, rx_empty_flag)
	wait_n(3);
	`CHK("raw_event", 7'h20, raw_event)
	`CHK("irq", 1'b0, irq)
	$display("test reset done");
	push_tx(8'hA5);
	tx_wr_valid <= 1'b0;
	wait_n(4);
	`CHK("tx_wr_ready", 1'b0, tx_wr_ready)
	`CHK("tx_event", 1'b0, raw_event[USF_EV_TX])
	push_rx(8'h3C);
	wait_n(3);
	`CHK("rx_full_flag", 1'b1, rx_full_flag)
	`CHK("rx_event", 1'b1, raw_event[USF_EV_RX])
	push_rx(8'h66);
	wait_n(3);
	`CHK("rx_overrun", 1'b1, rx_overrun)
	pop_rx;
	wait_n(3);
	`CHK("rx_event", 1'b0, raw_event[USF_EV_RX])
	event_mask_bit <= 7'h01;
	wait_n(3);
	`CHK("masked_event", 7'h01, masked_event)
	`CHK("irq", 1'b1, irq)
	event_mask_bit <= 7'h00;
	wait_n(3);
	`CHK("irq", 1'b0, irq)
	`CHK("ovr_event", 1'b1, raw_event[USF_EV_OVR])
	event_clear <= 7'h01;
	wait_n(1);
	event_clear <= 7'h00;
	wait_n(3);
	`CHK("ovr_event", 1'b0, raw_event[USF_EV_OVR])
	rx_timeout <= 1'b1;
	wait_n(1);
	rx_timeout <= 1'b0;
	wait_n(2);
	`CHK("tmo_event", 1'b1, raw_event[USF_EV_TMO])
	stall <= 1'b0;
	wait_n(10);
	`CHK("tx_event", 1'b1, raw_event[USF_EV_TX])
	$display("test holding mode done");
	port_enable <= 1'b0;
	divisor_int <= 16'h0004;
	fifo_enable_bit <= 1'b1;
	rx_level_select <= 3'h1;
	line_ctl_wr <= 1'b1;
	level_select_wr <= 1'b1;
	stall <= 1'b1;
	wait_n(1);
	line_ctl_wr <= 1'b0;
	level_select_wr <= 1'b0;
	port_enable <= 1'b1;
	for (int i = 1; i <= 17; i++) begin
		push_rx(8'($random(seed)));
		wait_n(3);
		if (i <= 6) `CHK("rx_event", 1'(i >= RXT), raw_event[USF_EV_RX])
	end
	`CHK("rx_full_flag", 1'b1, rx_full_flag)
	`CHK("ovr_event", 1'b1, raw_event[USF_EV_OVR])
	repeat (12) pop_rx;
	wait_n(3);
	`CHK("rx_event", 1'b1, raw_event[USF_EV_RX])
	pop_rx;
	wait_n(3);
	`CHK("rx_event", 1'b0, raw_event[USF_EV_RX])
	while (rxq.size() > 0) pop_rx;
	wait_n(3);
	`CHK("rx_empty_flag", 1'b1, rx_empty_flag)
	for (int i = 0; i < 16; i++) push_tx(8'($random(seed)));
	wait_n(3);
	`CHK("tx_full_flag", 1'b1, tx_full_flag)
	`CHK("tx_wr_ready", 1'b0, tx_wr_ready)
	`CHK("tx_event", 1'b0, raw_event[USF_EV_TX])
	tx_wr_data <= 8'hEE;
	wait_n(3);
	tx_wr_valid <= 1'b0;
	for (int n = 0; n < 400 && txq.size() > 0; n++) begin
		@(posedge sys_clk);
		stall <= 1'($random(seed));
	end
	stall <= 1'b0;
	wait_n(4);
	`CHK("tx_empty_flag", 1'b1, tx_empty_flag)
	`CHK("tx_event", 1'b1, raw_event[USF_EV_TX])
	$display("test fifo mode done");
	sir_enable <= 1'b1;
	busy <= 1'b1;
	for (int m = 0; m < 3; m++) begin
		line_level <= (m == 1);
		sir_lowpower <= (m == 2);
		lowpower_div <= 8'h01;
		wait_n(140);
		hi = 0;
		repeat (64) begin
			@(posedge sys_clk);
			if (serial_out_pin === 1'b1) hi++;
		end
		`CHK("pulse_cycles", (m == 0) ? 12 : (m == 1) ? 0 : 3, hi)
	end
	line_level <= 1'b1;
	sir_lowpower <= 1'b0;
	busy <= 1'b0;
	wait_n(140);
	ir_low <= 1'b1;
	wait_n(8);
	`CHK("rx_serial_bit", 1'b0, rx_serial_bit)
	ir_low <= 1'b0;
	wait_n(100);
	busy <= 1'b1;
	wait_n(4);
	ir_low <= 1'b1;
	wait_n(8);
	`CHK("rx_serial_bit", 1'b1, rx_serial_bit)
	ir_low <= 1'b0;
	busy <= 1'b0;
	sir_enable <= 1'b0;
	loopback_enable <= 1'b1;
	line_level <= 1'b0;
	wait_n(80);
	`CHK("loop_bit", 1'b0, rx_serial_bit)
	loopback_enable <= 1'b0;
	line_level <= 1'b1;
	$display("test infrared done");
	give_verdict;
end
endmodule
`default_nettype wire
